// File: hw/line_unit_register_bank_decode.sv
// Register bank with five-bit decode, bank pointer and serial or parallel host access.
// Assumes host strobes and serial pins are synchronous to CLK_IN; serial clock well below 12.5 MHz.
// What this block does
// - Decode only five address bits always
// - Non-multiplexed parallel address from A[4:0]
// - Multiplexed address from AD[4:0] latch
// - Serial address from command bits 5..1
// - Pointer at 1F selects the bank
// - Value AA routes addresses to expanded bank
// - Clearing pointer restores the primary bank
// - Primary 16..1E are reserved, no register
// - Expanded test registers reset to zero
// - Primary bank holds 22 registers, 00..15
// - Identity register is read-only
// - Pointer stays reachable in expanded bank
// - Serial flag 1 reads, 0 writes
// - Reading a status clears its flags
`timescale 1ns/1ps
`include "line_unit_regs.svh"
`default_nettype none

module line_unit_register_bank_decode
  import line_unit_pkg::*;
#(
  parameter byte_type IDENTITY_VALUE = 8'h5A // Arbitrary neutral value
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SERIAL_MODE_IN,
  input wire logic MUX_MODE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] AD_IN,
  input wire logic [7:0] PDATA_IN,
  input wire logic ADDR_LATCH_IN,
  input wire logic RD_STB_IN,
  input wire logic WR_STB_IN,
  input wire logic SER_SEL_N_IN,
  input wire logic SER_CLK_IN,
  input wire logic SER_DATA_IN,
  input wire logic [7:0] SIGNAL_ABSENCE_IN,
  input wire logic [7:0] DRIVER_FAULT_IN,
  input wire logic [7:0] ALARM_ONES_IN,
  output logic [7:0] PDATA_OUT,
  output logic PDATA_OE_OUT,
  output logic SER_DATA_OUT,
  output logic SER_DATA_OE_OUT,
  output logic EXP_BANK_OUT,
  output logic SOFT_RESET_OUT,
  output logic [7:0] ANALOG_LOOPBACK_OUT,
  output logic [7:0] REMOTE_LOOPBACK_OUT,
  output logic [7:0] ALL_ONES_OUT,
  output logic [7:0] DIGITAL_LOOPBACK_OUT,
  output logic [7:0] MONITOR_SELECT_OUT,
  output logic [7:0] DRIVER_ENABLE_OUT,
  output logic [7:0] SIGNAL_ABSENCE_FLAGS_OUT
);

  typedef struct packed {
    byte_type [21:0] prim;
    byte_type bank;
    byte_type [30:0] expd;
    byte_type [2:0] stat;
    byte_type [2:0] flag;
    byte_type pdata;
    logic poe;
    logic [4:0] latched_addr;
    ser_state_type ser;
    logic [3:0] bitcnt;
    byte_type cmd;
    byte_type shreg;
    logic sclk_q;
    logic serial_output_pin;
    logic sdo_oe;
    logic soft_reset;
    logic exp;
  } state_type;

  state_type s;
  state_type next_s;

  logic expanded;
  logic ser_rise;
  logic ser_fall;
  byte_type cmd_in;
  logic acc_rd;
  logic acc_wr;
  logic [4:0] acc_addr;
  byte_type acc_wdata;
  byte_type rdata;
  byte_type [2:0] set_bits;
  logic [2:0] status_read;

  // Only the exact key opens the expanded bank; any other value means primary
  assign expanded = (s.bank == `BANK_EXPANDED_KEY);
  assign ser_rise = SER_CLK_IN & ~s.sclk_q & ~SER_SEL_N_IN;
  assign ser_fall = ~SER_CLK_IN & s.sclk_q & ~SER_SEL_N_IN;
  // Bits arrive LSB first, so the first bit ends in position 0
  assign cmd_in = {SER_DATA_IN, s.cmd[7:1]};

  // One access path shared by both host ports; higher address bits are dropped here
  always_comb begin
    if (SERIAL_MODE_IN) begin
      acc_rd = ser_rise && (s.ser == SER_CMD) && (s.bitcnt == 4'h7) && cmd_in[0];
      acc_wr = ser_rise && (s.ser == SER_WRITE) && (s.bitcnt == 4'hF);
      acc_addr = (s.ser == SER_CMD) ? cmd_in[5:1] : s.cmd[5:1];
      acc_wdata = {SER_DATA_IN, s.shreg[7:1]};
    end else begin
      acc_rd = RD_STB_IN;
      acc_wr = WR_STB_IN;
      acc_addr = MUX_MODE_IN ? s.latched_addr : ADDR_IN[4:0];
      acc_wdata = MUX_MODE_IN ? AD_IN : PDATA_IN;
    end
  end

  // Read mux; the pointer is checked before the bank so it is never hidden
  always_comb begin
    rdata = 8'h00;
    if (acc_addr == `REG_BANK_POINTER) begin
      rdata = s.bank;
    end else if (expanded) begin
      rdata = s.expd[acc_addr];
    end else if (acc_addr > `REG_LAST_PRIMARY) begin
      rdata = 8'h00;
    end else begin
      unique case (acc_addr)
        `REG_DEVICE_IDENTITY: rdata = IDENTITY_VALUE;
        `REG_ABSENCE_STATUS: rdata = s.stat[0];
        `REG_FAULT_STATUS: rdata = s.stat[1];
        `REG_ALARM_STATUS: rdata = s.stat[2];
        `REG_ABSENCE_FLAGS: rdata = s.flag[0];
        `REG_FAULT_FLAGS: rdata = s.flag[1];
        `REG_ALARM_FLAGS: rdata = s.flag[2];
        `REG_SOFT_RESET: rdata = 8'h00; // Write-only command
        default: rdata = s.prim[acc_addr];
      endcase
    end
  end

  // Flags latch masked status changes; a status read clears its own flag byte
  assign set_bits[0] = (SIGNAL_ABSENCE_IN ^ s.stat[0]) & s.prim[`REG_ABSENCE_MASK];
  assign set_bits[1] = (DRIVER_FAULT_IN ^ s.stat[1]) & s.prim[`REG_FAULT_MASK];
  assign set_bits[2] = (ALARM_ONES_IN ^ s.stat[2]) & s.prim[`REG_ALARM_MASK];
  assign status_read[0] = acc_rd && !expanded && (acc_addr == `REG_ABSENCE_STATUS);
  assign status_read[1] = acc_rd && !expanded && (acc_addr == `REG_FAULT_STATUS);
  assign status_read[2] = acc_rd && !expanded && (acc_addr == `REG_ALARM_STATUS);

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    next_s.soft_reset = 1'b0;
    next_s.poe = 1'b0;
    next_s.sclk_q = SER_CLK_IN;
    next_s.stat[0] = SIGNAL_ABSENCE_IN;
    next_s.stat[1] = DRIVER_FAULT_IN;
    next_s.stat[2] = ALARM_ONES_IN;
    // Set wins over the read clear so no change is lost
    for (int i = 0; i < 3; i++) begin
      next_s.flag[i] = (status_read[i] ? 8'h00 : s.flag[i]) | set_bits[i];
    end
    if (ADDR_LATCH_IN) begin
      next_s.latched_addr = AD_IN[4:0];
    end
    // Register writes
    if (acc_wr) begin
      if (acc_addr == `REG_BANK_POINTER) begin
        next_s.bank = acc_wdata;
      end else if (expanded) begin
        next_s.expd[acc_addr] = acc_wdata;
      end else if (acc_addr == `REG_SOFT_RESET) begin
        next_s.soft_reset = 1'b1;
      end else if (acc_addr <= `REG_LAST_PRIMARY) begin
        unique case (acc_addr)
          `REG_DEVICE_IDENTITY, `REG_ABSENCE_STATUS, `REG_FAULT_STATUS, `REG_ALARM_STATUS,
          `REG_ABSENCE_FLAGS, `REG_FAULT_FLAGS, `REG_ALARM_FLAGS: ; // Read-only
          default: next_s.prim[acc_addr] = acc_wdata;
        endcase
      end
    end
    // Bank flag kept in its own flop so the output pin carries no compare logic
    next_s.exp = (next_s.bank == `BANK_EXPANDED_KEY);
    // Parallel read answer, data holds until the next read
    if (acc_rd && !SERIAL_MODE_IN) begin
      next_s.pdata = rdata;
      next_s.poe = 1'b1;
    end
    // Serial framing; deselect aborts any partial frame
    if (!SERIAL_MODE_IN || SER_SEL_N_IN) begin
      next_s.ser = SER_IDLE;
      next_s.bitcnt = 4'h0;
      next_s.sdo_oe = 1'b0;
    end else begin
      unique case (s.ser)
        SER_IDLE: next_s.ser = SER_CMD;
        SER_CMD: begin
          if (ser_rise) begin
            next_s.cmd = cmd_in;
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == 4'h7) begin
              next_s.ser = cmd_in[0] ? SER_READ : SER_WRITE;
              next_s.shreg = rdata;
            end
          end
        end
        SER_WRITE: begin
          if (ser_rise) begin
            next_s.shreg = acc_wdata;
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == 4'hF) begin
              next_s.ser = SER_IDLE;
            end
          end
        end
        SER_READ: begin
          // Output bits change on falling edges so the host samples on rising ones
          if (ser_fall) begin
            next_s.serial_output_pin = s.shreg[0];
            next_s.shreg = {1'b0, s.shreg[7:1]};
            next_s.sdo_oe = 1'b1;
          end
          if (ser_rise) begin
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == 4'hF) begin
              next_s.ser = SER_IDLE;
              next_s.sdo_oe = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // State register; reset clears every register including the test bank
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s <= '0;
      s.bank <= `BANK_POINTER_RESET;
      s.ser <= SER_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign PDATA_OUT = s.pdata;
  assign PDATA_OE_OUT = s.poe;
  assign SER_DATA_OUT = s.serial_output_pin;
  assign SER_DATA_OE_OUT = s.sdo_oe;
  assign EXP_BANK_OUT = s.exp;
  assign SOFT_RESET_OUT = s.soft_reset;
  assign ANALOG_LOOPBACK_OUT = s.prim[`REG_ANALOG_LOOPBACK];
  assign REMOTE_LOOPBACK_OUT = s.prim[`REG_REMOTE_LOOPBACK];
  assign ALL_ONES_OUT = s.prim[`REG_ALL_ONES];
  assign DIGITAL_LOOPBACK_OUT = s.prim[`REG_DIGITAL_LOOPBACK];
  assign MONITOR_SELECT_OUT = s.prim[`REG_MONITOR_SELECT];
  assign DRIVER_ENABLE_OUT = s.prim[`REG_OUTPUT_ENABLE];
  assign SIGNAL_ABSENCE_FLAGS_OUT = s.flag[0];

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence ser_read_cmd;
    ser_rise && (s.ser == SER_CMD) && (s.bitcnt == 4'h7) && cmd_in[0];
  endsequence

  sequence ser_read_loaded;
    (s.ser == SER_READ) && (s.bitcnt == 4'h8);
  endsequence

  a_bank_open: assert property (acc_wr && acc_addr == `REG_BANK_POINTER
    && acc_wdata == `BANK_EXPANDED_KEY |=> EXP_BANK_OUT)
    else $error("bank key did not open expanded bank");
  a_bank_close: assert property (acc_wr && acc_addr == `REG_BANK_POINTER && acc_wdata == 8'h00
    |=> !EXP_BANK_OUT) else $error("cleared pointer left expanded bank");
  a_pointer_reach: assert property (expanded && acc_wr && acc_addr == `REG_BANK_POINTER
    |=> s.bank == $past(acc_wdata)) else $error("pointer unreachable in expanded bank");
  a_reserved_ignored: assert property (acc_wr && !expanded && acc_addr > `REG_LAST_PRIMARY
    && acc_addr != `REG_BANK_POINTER |=> $stable(s.prim) && $stable(s.expd))
    else $error("reserved write stored");
  a_identity_read: assert property (acc_rd && !SERIAL_MODE_IN && !expanded
    && acc_addr == `REG_DEVICE_IDENTITY |=> PDATA_OE_OUT && PDATA_OUT == IDENTITY_VALUE)
    else $error("identity read wrong");
  a_five_bits: assert property (!SERIAL_MODE_IN && !MUX_MODE_IN && WR_STB_IN && !expanded
    && ADDR_IN[4:0] == `REG_ANALOG_LOOPBACK |=> ANALOG_LOOPBACK_OUT == $past(PDATA_IN))
    else $error("decode wrong");
  a_mux_latch: assert property (ADDR_LATCH_IN |=> s.latched_addr == $past(AD_IN[4:0]))
    else $error("multiplexed address not latched");
  a_flag_clear: assert property (status_read[0] && set_bits[0] == 8'h00 |=> s.flag[0] == 8'h00)
    else $error("flags not cleared by status read");
  a_flag_set: assert property (set_bits[1] != 8'h00
    |=> (s.flag[1] & $past(set_bits[1])) == $past(set_bits[1]))
    else $error("status change lost");
  a_ser_read: assert property (ser_read_cmd |=> ser_read_loaded ##0 (s.shreg == $past(rdata)))
    else $error("serial read not loaded");
  a_ser_write: assert property (SERIAL_MODE_IN && acc_wr && !expanded
    && acc_addr == `REG_REMOTE_LOOPBACK |=> REMOTE_LOOPBACK_OUT == $past(acc_wdata))
    else $error("serial write lost");
  // Only checked on release edges, so the unreset state at power-up is never judged
  a_test_zero: assert property (@(posedge CLK_IN) disable iff (1'b0) $past(RST_IN) && !RST_IN
    |-> s.expd == '0 && !EXP_BANK_OUT) else $error("test registers not zero after reset");
  a_soft_pulse: assert property (acc_wr && !expanded && acc_addr == `REG_SOFT_RESET
    |=> SOFT_RESET_OUT) else $error("soft reset write gave no pulse");
  a_soft_cause: assert property (SOFT_RESET_OUT
    |-> $past(acc_wr && !expanded && acc_addr == `REG_SOFT_RESET))
    else $error("soft reset pulse without write");
  a_ser_release: assert property (SERIAL_MODE_IN && SER_SEL_N_IN
    |=> !SER_DATA_OE_OUT) else $error("serial output driven while deselected");

endmodule

`default_nettype wire

// File: hw/line_unit_regs.svh
// Register map constants for the line unit register bank.
// Assumes a five-bit register address and byte-wide registers.
`ifndef LINE_UNIT_REGS_SVH
`define LINE_UNIT_REGS_SVH

`define ADDR_BITS 5
`define REG_DEVICE_IDENTITY 5'h00
`define REG_ANALOG_LOOPBACK 5'h01
`define REG_REMOTE_LOOPBACK 5'h02
`define REG_ALL_ONES 5'h03
`define REG_ABSENCE_STATUS 5'h04
`define REG_FAULT_STATUS 5'h05
`define REG_ABSENCE_MASK 5'h06
`define REG_FAULT_MASK 5'h07
`define REG_ABSENCE_FLAGS 5'h08
`define REG_FAULT_FLAGS 5'h09
`define REG_SOFT_RESET 5'h0A
`define REG_MONITOR_SELECT 5'h0B
`define REG_DIGITAL_LOOPBACK 5'h0C
`define REG_DETECT_CRITERIA 5'h0D
`define REG_AUTO_ALL_ONES 5'h0E
`define REG_GLOBAL_CONFIG 5'h0F
`define REG_TEMPLATE_INDEX 5'h10
`define REG_TEMPLATE_DATA 5'h11
`define REG_OUTPUT_ENABLE 5'h12
`define REG_ALARM_STATUS 5'h13
`define REG_ALARM_MASK 5'h14
`define REG_ALARM_FLAGS 5'h15
`define REG_LAST_PRIMARY 5'h15
`define REG_BANK_POINTER 5'h1F
`define BANK_EXPANDED_KEY 8'hAA
`define BANK_POINTER_RESET 8'h00
`define EXP_TEST_FIRST 5'h10
`define EXP_TEST_LAST 5'h1E

`endif

// File: hw/line_unit_pkg.sv
// Types shared by the line unit register bank.
// Assumes nothing beyond the constants header.
package line_unit_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_CMD = 4'b0010,
    SER_WRITE = 4'b0100,
    SER_READ = 4'b1000
  } ser_state_type;
endpackage

// File: bench/host_model.sv
// Host processor model: parallel strobes and serial frames.
// Assumes the block samples all pins on clk; serial clock idles low.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic mux,
  output logic [7:0] addr,
  output logic [7:0] ad,
  output logic [7:0] wdata,
  output logic ale,
  output logic rd,
  output logic wr,
  output logic sel_n,
  output logic sclk,
  output logic serial_input_pin,
  input wire logic serial_output_pin,
  output logic [7:0] rbyte,
  output logic done
);
  initial begin
    {addr, ad, wdata, ale, rd, wr, sclk, serial_input_pin, done, rbyte} = '0;
    sel_n = 1'b1;
  end
  // Upper address bits are random, since only five may be decoded
  task automatic put_addr(input logic [4:0] a);
    @(posedge clk);
    if (mux) begin
      ad <= {3'($urandom), a};
      ale <= 1'b1;
      @(posedge clk);
      ale <= 1'b0;
    end
    addr <= {3'($urandom), a};
  endtask
  task automatic pwrite(input logic [4:0] a, input logic [7:0] d);
    put_addr(a);
    wdata <= d;
    ad <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic pread(input logic [4:0] a);
    put_addr(a);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Command then data, LSB first; low phase 3 cycles so read data has settled
  task automatic frame(input logic [7:0] cmd, input logic [7:0] d);
    logic [15:0] w;
    w = {d, cmd};
    @(posedge clk);
    sel_n <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      sclk <= 1'b0;
      serial_input_pin <= w[i];
      repeat (3) @(posedge clk);
      if (i > 7) rbyte[i-8] <= serial_output_pin;
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    sclk <= 1'b0;
    sel_n <= 1'b1;
    serial_input_pin <= ~serial_input_pin; // Released line shows no stale value
    done <= cmd[0];
    @(posedge clk);
    done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/test_line_unit_register_bank_decode.sv
// Self-checking bench for the register bank in all three host modes.
// Assumes host_model drives the host pins; status inputs are driven here.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_line_unit_register_bank_decode;
  import line_unit_pkg::*;
  localparam byte_type IDV = 8'h3C; // Arbitrary identity value
  localparam logic [4:0] RW [14] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
                                     5'h10, 5'h11, 5'h12, 5'h14};
  localparam logic [4:0] ST [3] = '{5'h04, 5'h05, 5'h13};
  localparam logic [4:0] FL [3] = '{5'h08, 5'h09, 5'h15};
  logic clk = 1'b0, rst = 1'b1, ser_mode = 1'b0, mux = 1'b0;
  logic ale, rdst, wrst, sel_n, sclk, serial_input_pin, serial_output_pin, pdata_oe, exp_bank, done, ser_oe, srst;
  logic saw_oe = 1'b0;
  logic [7:0] addr, ad, wdata, rbyte, pdata, anlb, sflags, ev, remote_loopback_config, aones, digital_loopback_config, mon, drv;
  logic [7:0] abs_in = '0, flt_in = '0, ais_in = '0;
  logic [7:0] expq [$];
  int fails = 0, cmp_count = 0, srst_count = 0;
  host_model hm (.clk(clk), .mux(mux), .addr(addr), .ad(ad), .wdata(wdata), .ale(ale), .rd(rdst), .wr(wrst),
    .sel_n(sel_n), .sclk(sclk), .serial_input_pin(serial_input_pin), .serial_output_pin(serial_output_pin), .rbyte(rbyte), .done(done));
  line_unit_register_bank_decode #(.IDENTITY_VALUE(IDV)) DUT (.CLK_IN(clk), .RST_IN(rst),
    .SERIAL_MODE_IN(ser_mode), .MUX_MODE_IN(mux), .ADDR_IN(addr), .AD_IN(ad), .PDATA_IN(wdata),
    .ADDR_LATCH_IN(ale), .RD_STB_IN(rdst), .WR_STB_IN(wrst), .SER_SEL_N_IN(sel_n), .SER_CLK_IN(sclk),
    .SER_DATA_IN(serial_input_pin), .SIGNAL_ABSENCE_IN(abs_in), .DRIVER_FAULT_IN(flt_in), .ALARM_ONES_IN(ais_in),
    .PDATA_OUT(pdata), .PDATA_OE_OUT(pdata_oe), .SER_DATA_OUT(serial_output_pin), .SER_DATA_OE_OUT(ser_oe),
    .EXP_BANK_OUT(exp_bank), .SOFT_RESET_OUT(srst), .ANALOG_LOOPBACK_OUT(anlb), .REMOTE_LOOPBACK_OUT(remote_loopback_config),
    .ALL_ONES_OUT(aones), .DIGITAL_LOOPBACK_OUT(digital_loopback_config), .MONITOR_SELECT_OUT(mon), .DRIVER_ENABLE_OUT(drv),
    .SIGNAL_ABSENCE_FLAGS_OUT(sflags));
  initial begin
    forever #20 clk = ~clk;
  end
  // Every read answer takes the oldest expectation; negedge sees settled values
  always @(negedge clk) begin
    if (pdata_oe === 1'b1 || done === 1'b1) begin
      ev = expq.pop_front();
      `CHK("read data", ev, ser_mode ? rbyte : pdata)
    end
    // Soft reset pulses are counted; a stuck pulse counts more than once
    if (srst === 1'b1) srst_count++;
    // A read frame must have turned the serial driver on, and off again by its end
    if (ser_oe === 1'b1) saw_oe = 1'b1;
    if (done === 1'b1) begin
      `CHK("serial drive seen", 1'b1, saw_oe)
      `CHK("serial drive off", 1'b0, ser_oe)
      saw_oe = 1'b0;
    end
  end
  // Register access in whichever host mode is selected
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    if (ser_mode) hm.frame({2'($urandom), a, 1'b0}, d);
    else hm.pwrite(a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    expq.push_back(e);
    if (ser_mode) hm.frame({2'($urandom), a, 1'b1}, 8'($urandom));
    else hm.pread(a);
  endtask
  task automatic run_all();
    logic [7:0] v [32];
    logic [7:0] r;
    int n;
    abs_in <= '0;
    flt_in <= '0;
    ais_in <= '0;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(5'h00, IDV);
    wr(5'h00, ~IDV);
    rd(5'h00, IDV);
    foreach (RW[i]) begin
      v[RW[i]] = 8'($urandom);
      wr(RW[i], v[RW[i]]);
    end
    foreach (RW[i]) rd(RW[i], v[RW[i]]);
    `CHK("loopback pins", v[1], anlb)
    `CHK("remote loopback pins", v[2], remote_loopback_config)
    `CHK("all ones pins", v[3], aones)
    `CHK("monitor pins", v[11], mon)
    `CHK("digital loopback pins", v[12], digital_loopback_config)
    `CHK("driver enable pins", v[18], drv)
    for (int a = 'h16; a <= 'h1E; a++) begin
      wr(5'(a), 8'hFF);
      rd(5'(a), 8'h00);
    end
    rd(5'h0A, 8'h00);
    // A write to the command register gives exactly one pulse
    n = srst_count;
    wr(`REG_SOFT_RESET, 8'($urandom));
    repeat (2) @(posedge clk);
    `CHK("soft reset pulse", n + 1, srst_count)
    wr(`REG_BANK_POINTER, `BANK_EXPANDED_KEY);
    repeat (2) @(posedge clk);
    `CHK("bank select", 1'b1, exp_bank)
    rd(5'h10, 8'h00);
    rd(5'h1E, 8'h00);
    r = 8'($urandom);
    wr(5'h05, r);
    rd(5'h05, r);
    rd(`REG_BANK_POINTER, `BANK_EXPANDED_KEY);
    wr(`REG_BANK_POINTER, 8'h00);
    rd(5'h05, 8'h00);
    rd(5'h01, v[1]);
    // Masks first: a status change before them must not flag
    wr(5'h06, 8'hFF);
    wr(5'h07, 8'hFF);
    wr(5'h14, 8'hFF);
    r = 8'($urandom) | 8'h01;
    abs_in <= r;
    flt_in <= r;
    ais_in <= r;
    repeat (3) @(posedge clk);
    foreach (ST[i]) begin
      rd(FL[i], r);
      rd(ST[i], r);
      rd(FL[i], 8'h00);
    end
    `CHK("flag pins", 8'h00, sflags)
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test();
    if (expq.size() != 0) fails++;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(10632));
    run_all();
    mux <= 1'b1;
    run_all();
    ser_mode <= 1'b1;
    run_all();
    finish_test();
  end
  // Cut a hang short well beyond the expected run of about 6400 cycles
  initial begin
    #(40 * 40000);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
